// ---- include/irpl_cfg.svh ----
`ifndef IRPL_CFG_SVH
`define IRPL_CFG_SVH
// Soft-start settle time after isolated rail passes its threshold, in us
`define IRPL_SOFTSTART_US 5
`define IRPL_CLK_MHZ 125
`define IRPL_SOFTSTART_CYC (`IRPL_SOFTSTART_US * `IRPL_CLK_MHZ)
// AHB register byte addresses
`define IRPL_CTRL_ADDR 8'h00
`define IRPL_STAT_ADDR 8'h04
`define IRPL_IRQ_ADDR 8'h08
`define IRPL_MASK_ADDR 8'h0C
// Control field positions
`define IRPL_CTRL_DRV_EN 0
`define IRPL_CTRL_TXD 1
`define IRPL_CTRL_LISTEN_N 2
`define IRPL_CTRL_GP_IN 3
`define IRPL_CTRL_SEL_HI 4
`define IRPL_CTRL_CONV_EN 5
// Reset: driver off (pull-down), data high (pull-up), listener off,
// gp input low, select low (pull-down), converter enabled (open = on)
`define IRPL_CTRL_RST 6'h26
// Event positions
`define IRPL_EV_FAULT 0
`define IRPL_EV_UVLO 1
`define IRPL_EV_READY 2
`define IRPL_EV_BADSEL 3
`define IRPL_EV_W 4
`endif

// ---- include/irpl_pkg.sv ----
package irpl_pkg;
  typedef enum logic [1:0] {
    IRPL_OFF = 2'b00,
    IRPL_SOFT = 2'b01,
    IRPL_RUN = 2'b10
  } irpl_pwr_e;
  typedef logic [1:0] irpl_rail_t;
endpackage

// ---- core/irpl_top.sv ----
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "irpl_cfg.svh"
// How it works
// - Enabled driver drives Y and Z from the transmit data level.
// - Data high gives Y high, Z low; data low gives Y low, Z high.
// - Driver enable low puts Y and Z in high impedance.
// - Driver enable defaults low, so the driver starts disabled.
// - Transmit data defaults high, so an enabled driver sends one.
// - Listener on when its enable is low; above threshold gives high.
// - Below negative threshold gives low; the middle band is undefined.
// - Listener enable high or open makes its output high impedance.
// - Open, shorted or idle bus makes an enabled listener output high.
// - Powered and enabled, general output copies input; open input low.
// - General output high impedance when converter is off or unpowered.
// - Powered and enabled, isolated rail runs at the selected level; conv_supply_low_nom high forces the lower level.
// - Select defaults low, choosing the lower isolated level.
// - Either supply under threshold disables signal path and converter.
// - Driver stays high impedance until isolated rail passes threshold.
// - Converter supply fault pulls the alert low and stops converter.
module irpl_top
  import irpl_pkg::*;
#(
  parameter int SOFTSTART_CYC = `IRPL_SOFTSTART_CYC
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic conv_supply_ok,
  input wire logic logic_supply_ok,
  input wire logic conv_supply_low_nom,
  input wire logic conv_fault,
  input wire logic iso_rail_ok,
  input wire logic diff_above_pos,
  input wire logic diff_below_neg,
  input wire logic bus_failsafe,
  output logic bus_y_out,
  output logic bus_y_oe,
  output logic bus_z_out,
  output logic bus_z_oe,
  output logic rx_out,
  output logic rx_oe,
  output logic gp_out,
  output logic gp_oe,
  output logic alert_out,
  output logic alert_oe,
  output logic conv_on,
  output logic isolated_supply_rail_hi
);
  localparam int CW = $clog2(SOFTSTART_CYC + 1);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] s1_reg, s2_reg, s3_reg, in_reg;
  logic [2:0] s1_next, s2_next, s3_next, in_next;
  logic [2:0] pin_raw;
  assign pin_raw = {conv_fault, iso_rail_ok,
                    conv_supply_ok & logic_supply_ok};
  logic [3:0] b1_reg, b2_reg, b3_reg, bin_reg;
  logic [3:0] b1_next, b2_next, b3_next, bin_next;
  logic [3:0] bus_raw;
  assign bus_raw = {conv_supply_low_nom, bus_failsafe, diff_below_neg,
                    diff_above_pos};
  always_comb begin
    s1_next = pin_raw;
    s2_next = s1_reg;
    s3_next = s2_reg;
    // Accept a change only once two stages agree
    in_next = in_reg;
    for (int i = 0; i < 3; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        in_next[i] = s3_reg[i];
      end
    end
    b1_next = bus_raw;
    b2_next = b1_reg;
    b3_next = b2_reg;
    bin_next = bin_reg;
    for (int i = 0; i < 4; i++) begin
      if (b2_reg[i] == b3_reg[i]) begin
        bin_next[i] = b3_reg[i];
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
      s3_reg <= 3'h0;
      in_reg <= 3'h0;
      b1_reg <= 4'h0;
      b2_reg <= 4'h0;
      b3_reg <= 4'h0;
      bin_reg <= 4'h0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      in_reg <= in_next;
      b1_reg <= b1_next;
      b2_reg <= b2_next;
      b3_reg <= b3_next;
      bin_reg <= bin_next;
    end
  end
  logic sup_ok, rail_ok, fault;
  logic above, below, fsafe, low_nom;
  assign sup_ok = in_reg[0];
  assign rail_ok = in_reg[1];
  assign fault = in_reg[2];
  assign above = bin_reg[0];
  assign below = bin_reg[1];
  assign fsafe = bin_reg[2];
  assign low_nom = bin_reg[3];
  // ****************************************
  // AHB-Lite slave
  // ****************************************
  logic [5:0] ctrl_reg, ctrl_next;
  logic [3:0] irq_reg, irq_next;
  logic [3:0] mask_reg, mask_next;
  logic [7:0] a_reg, a_next;
  logic w_reg, w_next;
  logic [31:0] rd_reg, rd_next;
  logic [3:0] ev;
  logic ph;
  irpl_pwr_e st_reg, st_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic al_reg, al_next;
  assign ph = hsel & hready & htrans[1];
  always_comb begin
    a_next = a_reg;
    w_next = 1'b0;
    if (ph) begin
      a_next = haddr[7:0];
      w_next = hwrite;
    end
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    irq_next = irq_reg;
    if (w_reg) begin
      case (a_reg)
        `IRPL_CTRL_ADDR: ctrl_next = hwdata[5:0];
        `IRPL_MASK_ADDR: mask_next = hwdata[3:0];
        `IRPL_IRQ_ADDR: irq_next = irq_reg & ~hwdata[3:0];
        default: ;
      endcase
    end
    // Set wins over a simultaneous write-one clear
    irq_next = irq_next | ev;
    rd_next = 32'h0;
    if (ph && !hwrite) begin
      case (haddr[7:0])
        `IRPL_CTRL_ADDR: rd_next = {26'h0, ctrl_next};
        `IRPL_STAT_ADDR: rd_next = {24'h0, bin_reg, al_reg, st_reg, sup_ok};
        `IRPL_IRQ_ADDR: rd_next = {28'h0, irq_next};
        `IRPL_MASK_ADDR: rd_next = {28'h0, mask_next};
        default: rd_next = 32'h0;
      endcase
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rd_reg;
  assign irq = |(irq_reg & mask_reg);
  // ****************************************
  // Power sequencing
  // ****************************************
  logic en_pin, sel_hi;
  assign en_pin = ctrl_reg[`IRPL_CTRL_CONV_EN] & ~al_reg;
  assign sel_hi = ctrl_reg[`IRPL_CTRL_SEL_HI];
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    al_next = al_reg;
    if (fault) begin
      al_next = 1'b1;
    end else if (!ctrl_reg[`IRPL_CTRL_CONV_EN]) begin
      al_next = 1'b0;
    end
    case (st_reg)
      IRPL_OFF: begin
        cnt_next = '0;
        if (sup_ok && en_pin && !fault) begin
          st_next = IRPL_SOFT;
        end
      end
      IRPL_SOFT: begin
        // Count only once the isolated rail is past its threshold
        if (rail_ok) begin
          cnt_next = cnt_reg + CW'(1);
        end
        if (cnt_reg == CW'(SOFTSTART_CYC)) begin
          st_next = IRPL_RUN;
        end
      end
      IRPL_RUN: ;
      default: st_next = IRPL_OFF;
    endcase
    if (!sup_ok || !en_pin || fault) begin
      st_next = IRPL_OFF;
    end
  end
  assign ev[`IRPL_EV_FAULT] = fault & ~al_reg;
  assign ev[`IRPL_EV_UVLO] = (st_reg != IRPL_OFF) & ~sup_ok;
  assign ev[`IRPL_EV_READY] = (st_reg == IRPL_SOFT) & (st_next == IRPL_RUN);
  assign ev[`IRPL_EV_BADSEL] = (st_reg == IRPL_RUN) & sel_hi & low_nom;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `IRPL_CTRL_RST;
      irq_reg <= 4'h0;
      mask_reg <= 4'h0;
      a_reg <= 8'h00;
      w_reg <= 1'b0;
      rd_reg <= 32'h0;
      st_reg <= IRPL_OFF;
      cnt_reg <= '0;
      al_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      irq_reg <= irq_next;
      mask_reg <= mask_next;
      a_reg <= a_next;
      w_reg <= w_next;
      rd_reg <= rd_next;
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      al_reg <= al_next;
    end
  end
  // ****************************************
  // Pin outputs
  // ****************************************
  logic run, drv_on, rx_on;
  logic [11:0] o_next, o_reg;
  assign run = (st_reg == IRPL_RUN);
  assign drv_on = run & ctrl_reg[`IRPL_CTRL_DRV_EN];
  assign rx_on = run & ~ctrl_reg[`IRPL_CTRL_LISTEN_N];
  always_comb begin
    o_next = 12'h0;
    o_next[0] = ctrl_reg[`IRPL_CTRL_TXD];
    o_next[1] = drv_on;
    o_next[2] = ~ctrl_reg[`IRPL_CTRL_TXD];
    o_next[3] = drv_on;
    // Middle band has no defined level; hold it low here
    o_next[4] = fsafe | above;
    o_next[5] = rx_on;
    o_next[6] = ctrl_reg[`IRPL_CTRL_GP_IN];
    o_next[7] = run;
    o_next[8] = 1'b0;
    o_next[9] = al_reg;
    o_next[10] = run | (st_reg == IRPL_SOFT);
    o_next[11] = sel_hi & ~low_nom;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      o_reg <= 12'h0;
    end else begin
      o_reg <= o_next;
    end
  end
  assign bus_y_out = o_reg[0];
  assign bus_y_oe = o_reg[1];
  assign bus_z_out = o_reg[2];
  assign bus_z_oe = o_reg[3];
  assign rx_out = o_reg[4];
  assign rx_oe = o_reg[5];
  assign gp_out = o_reg[6];
  assign gp_oe = o_reg[7];
  assign alert_out = o_reg[8];
  assign alert_oe = o_reg[9];
  assign conv_on = o_reg[10];
  assign isolated_supply_rail_hi = o_reg[11];
  // ****************************************
  // Checks
  // ****************************************
  chk_drv_polarity: assert property (
    @(posedge hclk) disable iff (!hresetn)
    bus_y_oe |-> bus_z_out == ~bus_y_out)
    else $error("driver outputs not complementary");
  chk_drv_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    bus_y_oe |-> $past(run))
    else $error("driver on before run");
  chk_drv_off: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !$past(ctrl_reg[0]) |-> !bus_y_oe && !bus_z_oe)
    else $error("driver on while disabled");
  chk_rx_off: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $past(ctrl_reg[2]) |-> !rx_oe)
    else $error("listener on while disabled");
  chk_rx_fsafe: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rx_oe && $past(fsafe) |-> rx_out)
    else $error("failsafe not high");
  chk_rx_low: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rx_oe && $past(below) && !$past(fsafe) && !$past(above) |-> !rx_out)
    else $error("listener not low");
  chk_gp_off: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !sup_ok |=> ##1 !gp_oe)
    else $error("general output on without supply");
  chk_alert_low: assert property (
    @(posedge hclk) disable iff (!hresetn)
    fault |=> ##1 alert_oe && !alert_out && !conv_on)
    else $error("fault not flagged");
  chk_uv_stop: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !sup_ok |=> st_reg == IRPL_OFF)
    else $error("path alive under undervoltage");
endmodule

// ---- sim/irpl_bus_node.sv ----
`timescale 1ns/100ps
// ****
// Far-side nodes on the twisted pair
// ****
module irpl_bus_node (
  input wire logic hclk,
  input wire logic [1:0] level,
  output logic diff_above_pos,
  output logic diff_below_neg,
  output logic bus_failsafe
);
  // 0: a node drives one, 1: a node drives zero, 2: nobody drives
  always_ff @(posedge hclk) begin
    diff_above_pos <= (level == 2'h0);
    diff_below_neg <= (level == 2'h1);
    bus_failsafe <= (level == 2'h2);
  end
endmodule

// ---- sim/tb_irpl_top.sv ----
`timescale 1ns/100ps
`include "irpl_cfg.svh"
module tb_irpl_top;
  import irpl_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic conv_supply_ok = 1'b1;
  logic logic_supply_ok = 1'b1;
  logic conv_supply_low_nom = 1'b0;
  logic conv_fault = 1'b0;
  logic iso_rail_ok = 1'b0;
  logic [1:0] level = 2'h2;
  wire diff_above_pos, diff_below_neg, bus_failsafe;
  wire [31:0] hrdata;
  wire hreadyout, hresp, irq, bus_y_out, bus_y_oe, bus_z_out, bus_z_oe;
  wire rx_out, rx_oe, gp_out, gp_oe, alert_out, alert_oe, conv_on;
  wire isolated_supply_rail_hi;
  int n_errors = 0;
  int check_count = 0;
  logic [31:0] q;
  // ****
  // Clock, design and far side
  // ****
  always #4 hclk = ~hclk;
  irpl_top #(.SOFTSTART_CYC(4)) u_irpl_top (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .irq, .conv_supply_ok, .logic_supply_ok,
    .conv_supply_low_nom, .conv_fault, .iso_rail_ok, .diff_above_pos,
    .diff_below_neg, .bus_failsafe, .bus_y_out, .bus_y_oe, .bus_z_out,
    .bus_z_oe, .rx_out, .rx_oe, .gp_out, .gp_oe, .alert_out, .alert_oe,
    .conv_on, .isolated_supply_rail_hi);
  irpl_bus_node u_irpl_bus_node (.hclk, .level, .diff_above_pos,
    .diff_below_neg, .bus_failsafe);
  // ****
  // Bus and check tasks
  // ****
  // Called right after a rising edge; returns right after one
  task automatic xfer(input logic w, input logic [31:0] a,
    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    r = hrdata;
    if (n >= 50) begin
      n_errors++;
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h0, r);
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Synchroniser plus output stage take five edges
  task automatic settle();
    repeat (8) @(posedge hclk);
  endtask
  task automatic wait_run();
    int n;
    n = 0;
    do rd(`IRPL_STAT_ADDR, q); while (q[2:1] !== IRPL_RUN && ++n < 100);
    check(q[2:1], IRPL_RUN);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`IRPL_CTRL_ADDR, q);
    check(q, 32'h26);
    check(hresp, 1'b0);
    wr(`IRPL_CTRL_ADDR, 32'h27);
    settle();
    check({conv_on, bus_y_oe, bus_z_oe}, 3'h4);
    iso_rail_ok <= 1'b1;
    wait_run();
    settle();
    check({bus_y_oe, bus_z_oe, bus_y_out, bus_z_out}, 4'hE);
    check({rx_oe, isolated_supply_rail_hi, gp_oe, gp_out}, 4'h2);
    wr(`IRPL_CTRL_ADDR, 32'h21);
    settle();
    check({bus_y_oe, bus_z_oe, bus_y_out, bus_z_out}, 4'hD);
    wr(`IRPL_CTRL_ADDR, 32'h20);
    settle();
    check({bus_y_oe, bus_z_oe}, 2'h0);
    wr(`IRPL_CTRL_ADDR, 32'h38);
    settle();
    check({gp_oe, gp_out, isolated_supply_rail_hi, rx_oe}, 4'hF);
    for (int lv = 0; lv < 3; lv++) begin
      level <= lv[1:0];
      settle();
      check(rx_out, lv != 1);
    end
    rd(32'h10, q);
    check(q, 32'h0);
    wr(`IRPL_MASK_ADDR, 32'hF);
    wr(`IRPL_IRQ_ADDR, 32'hF);
    settle();
    check(irq, 1'b0);
    conv_fault <= 1'b1;
    settle();
    check({alert_oe, alert_out, conv_on, gp_oe}, 4'h8);
    check(irq, 1'b1);
    rd(`IRPL_IRQ_ADDR, q);
    check(q[0], 1'b1);
    conv_fault <= 1'b0;
    wr(`IRPL_MASK_ADDR, 32'h0);
    settle();
    check(irq, 1'b0);
    wr(`IRPL_IRQ_ADDR, 32'h1);
    wr(`IRPL_MASK_ADDR, 32'hF);
    settle();
    check(irq, 1'b0);
    wr(`IRPL_CTRL_ADDR, 32'h18);
    settle();
    check({alert_oe, conv_on, gp_oe}, 3'h0);
    wr(`IRPL_CTRL_ADDR, 32'h38);
    wait_run();
    logic_supply_ok <= 1'b0;
    settle();
    check({conv_on, rx_oe, gp_oe}, 3'h0);
    rd(`IRPL_IRQ_ADDR, q);
    check(q[1], 1'b1);
    end_of_test();
  end
endmodule
